/* logic/dpc_controller.sv */
// dual-port ram controller: refresh, local port and system-bus port arbitration
// Contract
// R1: array is 32K bytes; both ports decode only inside that size.
// R2: refresh always wins the arbiter, so it is never starved.
// R3: simultaneous local and system-bus requests: local goes first.
// R4: each port has its own address decoder and base.
// R5: local port sees the ram starting at address zero.
// R6: system-bus base is strapped on any 8K boundary in 1M space.
// R7: a strapped contiguous range of 8K segments refuses system-bus access.
// R8: system bus moves bytes or words; local port moves 16-bit words.
// R9: local accesses never involve the system-bus handshake.
// R10: system master holds request until ack; ack withheld while busy or protected.
module dpc_controller
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic locReq,
   input wire logic locWrite,
   input wire logic [dpc_pkg::ADDR_W-1:0] locAddr,
   input wire logic [dpc_pkg::DATA_W-1:0] locWdata,
   output logic [dpc_pkg::DATA_W-1:0] locRdata,
   output logic locAck,
   input wire logic sysReq,
   input wire logic sysWrite,
   input wire logic sysByte,
   input wire logic [dpc_pkg::ADDR_W-1:0] sysAddr,
   input wire logic [dpc_pkg::DATA_W-1:0] sysWdata,
   output logic [dpc_pkg::DATA_W-1:0] sysRdata,
   output logic sysAck,
   input wire logic [dpc_pkg::BASE_W-1:0] sysBaseStrap,
   input wire logic protEnStrap,
   input wire logic [dpc_pkg::PSEG_W-1:0] protLoStrap,
   input wire logic [dpc_pkg::PSEG_W-1:0] protHiStrap,
   output logic [dpc_pkg::ROW_W-1:0] refreshRow
);
   import dpc_pkg::*;

   localparam int SYNC_W = 3 + ADDR_W + DATA_W + BASE_W + 1 + 2 * PSEG_W;

   function automatic logic [WORD_AW-1:0] wordOf(input logic [ADDR_W-1:0] a);
      wordOf = a[WORD_AW:1];
   endfunction

   // system-bus and strap inputs are asynchronous; the grant waits a cycle more for skew
   logic [SYNC_W-1:0] syncMeta;
   logic [SYNC_W-1:0] syncOut;
   logic sysReqS;
   logic sysWriteS;
   logic sysByteS;
   logic [ADDR_W-1:0] sysAddrS;
   logic [DATA_W-1:0] sysWdataS;
   logic [BASE_W-1:0] sysBaseS;
   logic protEnS;
   logic [PSEG_W-1:0] protLoS;
   logic [PSEG_W-1:0] protHiS;
   logic sysSeen_reg;

   always_ff @(posedge clk)
   begin
      syncMeta <= {sysReq, sysWrite, sysByte, sysAddr, sysWdata, sysBaseStrap, protEnStrap,
                   protLoStrap, protHiStrap};
      syncOut <= syncMeta;
      sysSeen_reg <= sysReqS;
   end

   assign {sysReqS, sysWriteS, sysByteS, sysAddrS, sysWdataS, sysBaseS, protEnS, protLoS,
           protHiS} = syncOut;

   // address decode, one per port
   logic locHit;
   logic sysHit;
   logic sysProt;
   logic [ADDR_W-1:0] sysBaseAddr;
   logic [ADDR_W-1:0] sysOff;
   logic [PSEG_W-1:0] sysSeg;

   assign locHit = (locAddr - LOC_BASE) < RAM_BYTES; // [R5] [R1]
   assign sysBaseAddr = {sysBaseS, {SEG_SHIFT{1'b0}}}; // [R6]
   assign sysOff = sysAddrS - sysBaseAddr; // [R4]
   assign sysHit = (sysAddrS >= sysBaseAddr) && (sysOff < RAM_BYTES); // [R1] [R6]
   assign sysSeg = sysOff[SEG_SHIFT+PSEG_W-1:SEG_SHIFT];
   assign sysProt = protEnS && (sysSeg >= protLoS) && (sysSeg <= protHiS); // [R7]

   dpc_state_e state_reg;
   dpc_state_e state_next;
   logic [REF_CNT_W-1:0] refCnt_reg;
   logic [REF_CNT_W-1:0] refCnt_next;
   logic refPend_reg;
   logic refPend_next;
   logic [2:0] busyCnt_reg;
   logic [2:0] busyCnt_next;
   logic [ROW_W-1:0] refreshRow_reg;
   logic [ROW_W-1:0] refreshRow_next;
   logic locAck_reg;
   logic locAck_next;
   logic [DATA_W-1:0] locRdata_reg;
   logic [DATA_W-1:0] locRdata_next;
   logic sysAck_reg;
   logic sysAck_next;
   logic [DATA_W-1:0] sysRdata_reg;
   logic [DATA_W-1:0] sysRdata_next;
   logic locGo;
   logic sysGo;
   logic memWe;
   logic [1:0] memBe;
   logic [WORD_AW-1:0] memAddr;
   logic [DATA_W-1:0] memWdata;
   logic [DATA_W-1:0] memRdata;

   // local blocked during its own ack cycle so a held request is not served twice
   assign locGo = locReq && locHit && !locAck_reg;
   // system port waits for the master to drop its request after each ack
   assign sysGo = sysReqS && sysSeen_reg && sysHit && !sysProt && !sysAck_reg; // [R7] [R10]

   always_comb
   begin
      state_next = state_reg;
      refCnt_next = refCnt_reg - 1'b1;
      refPend_next = refPend_reg;
      busyCnt_next = busyCnt_reg;
      refreshRow_next = refreshRow_reg;
      locAck_next = 1'b0;
      locRdata_next = locRdata_reg;
      sysAck_next = sysAck_reg && sysReqS; // [R10]
      sysRdata_next = sysRdata_reg;
      memWe = 1'b0;
      memBe = BE_WORD;
      memAddr = wordOf(locAddr);
      memWdata = locWdata;
      unique case (state_reg)
         ST_IDLE:
         begin
            if (refPend_reg) // [R2]
            begin
               state_next = ST_REFRESH;
               refPend_next = 1'b0;
               busyCnt_next = REF_BUSY_CYC - 3'h1;
            end
            else if (locGo) // [R3] [R9]
            begin
               state_next = ST_LOCDONE;
               memWe = locWrite; // [R8]
            end
            else if (sysGo)
            begin
               state_next = ST_SYSDONE;
               memWe = sysWriteS;
               memAddr = wordOf(sysOff);
               if (sysByteS) // [R8]
               begin
                  memBe = sysOff[0] ? BE_HIGH : BE_LOW;
                  memWdata = {sysWdataS[7:0], sysWdataS[7:0]};
               end
               else
               begin
                  memWdata = sysWdataS;
               end
            end
         end
         ST_REFRESH:
         begin
            // the slot lasts the full refresh time whatever is waiting
            busyCnt_next = busyCnt_reg - 3'h1;
            if (busyCnt_reg == 3'h0)
            begin
               state_next = ST_IDLE;
               refreshRow_next = refreshRow_reg + 1'b1;
            end
         end
         ST_LOCDONE:
         begin
            state_next = ST_IDLE;
            locAck_next = 1'b1;
            locRdata_next = memRdata; // [R8]
         end
         ST_SYSDONE:
         begin
            state_next = ST_IDLE;
            sysAck_next = 1'b1; // [R10]
            if (sysByteS)
            begin
               sysRdata_next = {8'h00, sysOff[0] ? memRdata[15:8] : memRdata[7:0]};
            end
            else
            begin
               sysRdata_next = memRdata;
            end
         end
      endcase
      // a new refresh demand in the same cycle as the grant is kept
      if (refCnt_reg == '0)
      begin
         refCnt_next = REF_INTERVAL - 1'b1;
         refPend_next = 1'b1; // [R2]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         refCnt_reg <= REF_INTERVAL - 1'b1;
         refPend_reg <= 1'b0;
         busyCnt_reg <= 3'h0;
         refreshRow_reg <= '0;
         locAck_reg <= 1'b0;
         locRdata_reg <= '0;
         sysAck_reg <= 1'b0;
         sysRdata_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         refCnt_reg <= refCnt_next;
         refPend_reg <= refPend_next;
         busyCnt_reg <= busyCnt_next;
         refreshRow_reg <= refreshRow_next;
         locAck_reg <= locAck_next;
         locRdata_reg <= locRdata_next;
         sysAck_reg <= sysAck_next;
         sysRdata_reg <= sysRdata_next;
      end
   end

   dpc_ram u_dpc_ram
   (
      .clk(clk),
      .we(memWe),
      .be(memBe),
      .addr(memAddr),
      .wdata(memWdata),
      .rdata(memRdata)
   );

   assign locAck = locAck_reg;
   assign locRdata = locRdata_reg;
   assign sysAck = sysAck_reg;
   assign sysRdata = sysRdata_reg;
   assign refreshRow = refreshRow_reg;

   AST_LOC_IN_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
      $rose(locAck) |-> $past(locAddr, 2) < RAM_BYTES)
      else $error("local ack for address outside the array");

   AST_REF_FIRST: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      (state_reg == ST_IDLE && refPend_reg) |=> state_reg == ST_REFRESH)
      else $error("pending refresh not granted first");

   AST_REF_LEN: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      $rose(state_reg == ST_REFRESH) |-> (state_reg == ST_REFRESH) [*4] ##1 state_reg == ST_IDLE)
      else $error("refresh slot length wrong");

   AST_LOC_OVER_SYS: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
      (state_reg == ST_IDLE && !refPend_reg && locGo && sysGo) |=> state_reg == ST_LOCDONE)
      else $error("system bus granted ahead of local");

   AST_LOC_LATENCY: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
      (state_reg == ST_IDLE && !refPend_reg && locGo) |-> ##2 locAck && !$rose(sysAck_reg))
      else $error("local access not acked two cycles after grant");

   AST_SYS_DECODE: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
      (state_reg == ST_SYSDONE) |-> $past(sysHit) && !$past(sysProt))
      else $error("system access granted outside its window");

   AST_PROT_NO_ACK: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
      (sysReqS && sysProt && !sysAck_reg) |=> !sysAck_reg)
      else $error("ack given to a protected address");

   AST_BYTE_LANE: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      (state_reg == ST_IDLE && !refPend_reg && !locGo && sysGo && sysByteS) |-> memBe != BE_WORD)
      else $error("byte access enabled both lanes");

   AST_ACK_CAUSE: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
      $rose(sysAck_reg) |-> $past(state_reg) == ST_SYSDONE)
      else $error("system ack without a completed access");

   AST_ACK_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
      (sysAck_reg && sysReqS) |=> sysAck_reg)
      else $error("system ack dropped while request held");

   COV_REFRESH: cover property (@(posedge clk) disable iff (!rst_n)
      state_reg == ST_REFRESH);
   COV_CONTEND: cover property (@(posedge clk) disable iff (!rst_n)
      state_reg == ST_IDLE && locGo && sysGo);
   COV_SYS_BYTE: cover property (@(posedge clk) disable iff (!rst_n)
      state_reg == ST_SYSDONE && sysByteS);
   COV_PROT: cover property (@(posedge clk) disable iff (!rst_n)
      sysReqS && sysHit && sysProt);
endmodule

/* logic/dpc_pkg.sv */
// shared constants and types for the dual-port ram controller
package dpc_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int WORD_AW = 14;
   localparam int SEG_SHIFT = 13;
   localparam int BASE_W = ADDR_W - SEG_SHIFT;
   localparam int PSEG_W = 2;
   localparam int ROW_W = 7;
   localparam logic [ADDR_W-1:0] RAM_BYTES = 20'h08000;
   localparam logic [ADDR_W-1:0] LOC_BASE = 20'h00000;
   localparam int CLK_PERIOD_NS = 40;
   // longest gap between refresh slots, rounded down
   localparam int REF_PERIOD_NS = 15600;
   localparam int REF_CNT_W = 9;
   localparam logic [REF_CNT_W-1:0] REF_INTERVAL = REF_CNT_W'(REF_PERIOD_NS / CLK_PERIOD_NS);
   // least time the array is held for one refresh, rounded up
   localparam int REF_BUSY_NS = 160;
   localparam logic [2:0] REF_BUSY_CYC = 3'((REF_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] BE_WORD = 2'h3;
   localparam logic [1:0] BE_LOW = 2'h1;
   localparam logic [1:0] BE_HIGH = 2'h2;
   typedef enum logic [1:0] {ST_IDLE, ST_REFRESH, ST_LOCDONE, ST_SYSDONE} dpc_state_e;
endpackage

/* logic/dpc_ram.sv */
// word-wide storage array with byte lanes and registered read data
module dpc_ram
(
   input wire logic clk,
   input wire logic we,
   input wire logic [1:0] be,
   input wire logic [dpc_pkg::WORD_AW-1:0] addr,
   input wire logic [dpc_pkg::DATA_W-1:0] wdata,
   output logic [dpc_pkg::DATA_W-1:0] rdata
);
   import dpc_pkg::*;
   logic [DATA_W-1:0] mem [0:(1<<WORD_AW)-1];

   always_ff @(posedge clk)
   begin
      if (we && be[0])
      begin
         mem[addr][7:0] <= wdata[7:0];
      end
      if (we && be[1])
      begin
         mem[addr][15:8] <= wdata[15:8];
      end
      rdata <= mem[addr];
   end
endmodule

/* tb/dpc_controller_tb.sv */
// self-checking bench for the dual-port ram controller
module dpc_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dpc_pkg::*;
   localparam logic [ADDR_W-1:0] SYS0 = 20'h0a000;
   logic clk, rst_n, locReq, locWrite, locAck, sysReq, sysWrite, sysByte, sysAck, ok;
   logic [ADDR_W-1:0] locAddr, sysAddr;
   logic [DATA_W-1:0] locWdata, locRdata, sysWdata, sysRdata, rd;
   logic [ROW_W-1:0] refreshRow;
   logic [BASE_W-1:0] sysBaseStrap;
   logic protEnStrap;
   logic [PSEG_W-1:0] protLoStrap, protHiStrap;
   int n_fail = 0;
   int compares = 0;
   dpc_controller u_dpc_controller (.clk(clk), .rst_n(rst_n), .locReq(locReq),
      .locWrite(locWrite), .locAddr(locAddr), .locWdata(locWdata), .locRdata(locRdata),
      .locAck(locAck), .sysReq(sysReq), .sysWrite(sysWrite), .sysByte(sysByte),
      .sysAddr(sysAddr), .sysWdata(sysWdata), .sysRdata(sysRdata), .sysAck(sysAck),
      .sysBaseStrap(sysBaseStrap), .protEnStrap(protEnStrap), .protLoStrap(protLoStrap),
      .protHiStrap(protHiStrap),
      .refreshRow(refreshRow));
   dpc_sys_master u_dpc_sys_master (.clk(clk), .sysAck(sysAck), .sysRdata(sysRdata),
      .sysReq(sysReq), .sysWrite(sysWrite), .sysByte(sysByte), .sysAddr(sysAddr),
      .sysWdata(sysWdata));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic loc(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] wd);
      int n;
      ok = 1'b0;
      @(posedge clk);
      #1;
      locWrite = wr;
      locAddr = a;
      locWdata = wd;
      locReq = 1'b1;
      for (n = 0; n < 20 && !ok; n++)
      begin
         @(posedge clk);
         #1;
         ok = (locAck === 1'b1);
      end
      // hold through the edge that samples the ack, then take the word
      @(posedge clk);
      #1;
      rd = locRdata;
      locReq = 1'b0;
      locAddr = ~a;
      locWdata = ~wd;
   endtask
   task automatic sys(input logic wr, input logic byt, input logic [ADDR_W-1:0] a,
      input logic [15:0] wd);
      u_dpc_sys_master.xfer(wr, byt, a, wd, rd, ok);
   endtask
   task automatic t_local();
      loc(1'b1, 20'h00000, 16'h1234);
      chk("loc wr 0 ack", 16'h1, {15'h0, ok});
      loc(1'b1, 20'h07ffe, 16'hbeef);
      loc(1'b0, 20'h07ffe, 16'h0000);
      chk("loc top word", 16'hbeef, rd);
      loc(1'b1, 20'h08000, 16'h5555);
      chk("loc unmapped ack", 16'h0, {15'h0, ok});
      loc(1'b0, 20'h00000, 16'h0000);
      chk("loc word 0", 16'h1234, rd);
      chk("sysAck idle", 16'h0, {15'h0, sysAck});
   endtask
   task automatic t_sysport();
      sys(1'b1, 1'b1, SYS0 + 20'h1, 16'h00a5);
      chk("sys byte wr ack", 16'h1, {15'h0, ok});
      loc(1'b0, 20'h00000, 16'h0000);
      chk("loc sees high lane", 16'ha534, rd);
      sys(1'b0, 1'b1, SYS0, 16'h0000);
      chk("sys byte rd even", 16'h0034, rd);
      sys(1'b0, 1'b1, SYS0 + 20'h1, 16'h0000);
      chk("sys byte rd odd", 16'h00a5, rd);
      sys(1'b1, 1'b0, SYS0 + 20'h20, 16'hcafe);
      sys(1'b0, 1'b0, SYS0 + 20'h20, 16'h0000);
      chk("sys word rd", 16'hcafe, rd);
      sys(1'b0, 1'b0, 20'h00020, 16'h0000);
      chk("sys below base ack", 16'h0, {15'h0, ok});
      sys(1'b0, 1'b0, SYS0 + 20'h8000, 16'h0000);
      chk("sys past top ack", 16'h0, {15'h0, ok});
   endtask
   task automatic t_protect();
      loc(1'b1, 20'h06000, 16'h2222);
      chk("loc in window ack", 16'h1, {15'h0, ok});
      sys(1'b1, 1'b0, SYS0 + 20'h6000, 16'h7777);
      chk("sys protected ack", 16'h0, {15'h0, ok});
      sys(1'b1, 1'b0, SYS0 + 20'h5ffe, 16'h1111);
      chk("sys below window ack", 16'h1, {15'h0, ok});
      loc(1'b0, 20'h06000, 16'h0000);
      chk("protected word kept", 16'h2222, rd);
      loc(1'b0, 20'h05ffe, 16'h0000);
      chk("loc sees sys word", 16'h1111, rd);
   endtask
   task automatic t_priority();
      logic [15:0] r1;
      logic o1;
      time tl, ts;
      int n;
      // the local request meets the synchronised system request at the arbiter
      fork
         u_dpc_sys_master.xfer(1'b0, 1'b0, SYS0 + 20'h20, 16'h0000, r1, o1);
         begin
            for (n = 0; n < 40; n++)
            begin
               @(posedge clk);
               #1;
               if (sysAck === 1'b1)
                  break;
            end
            ts = $time;
         end
         begin
            repeat (3)
               @(posedge clk);
            loc(1'b0, 20'h00000, 16'h0000);
            tl = $time;
         end
      join
      chk("local granted first", 16'h1, {15'h0, tl < ts});
      chk("sys rd after wait", 16'hcafe, r1);
   endtask
   task automatic t_straps();
      // straps pass the synchroniser like the bus, so let them settle first
      @(posedge clk);
      #1;
      sysBaseStrap = 7'h00;
      protLoStrap = 2'h1;
      protHiStrap = 2'h2;
      repeat (3)
         @(posedge clk);
      sys(1'b0, 1'b0, 20'h00020, 16'h0000);
      chk("sys rd at base 0", 16'hcafe, rd);
      sys(1'b1, 1'b0, 20'h04000, 16'h7777);
      chk("sys seg 2 protected ack", 16'h0, {15'h0, ok});
      sys(1'b1, 1'b0, 20'h01ffe, 16'h4444);
      chk("sys seg 0 open ack", 16'h1, {15'h0, ok});
      @(posedge clk);
      #1;
      protEnStrap = 1'b0;
      repeat (3)
         @(posedge clk);
      sys(1'b1, 1'b0, 20'h04000, 16'h3333);
      chk("sys unprotected ack", 16'h1, {15'h0, ok});
      loc(1'b0, 20'h04000, 16'h0000);
      chk("loc sees unprotected write", 16'h3333, rd);
   endtask
   task automatic t_refresh();
      logic [ROW_W-1:0] row0;
      row0 = refreshRow;
      // back-to-back local traffic must not starve refresh
      repeat (150)
         loc(1'b1, 20'h00100, 16'h0f0f);
      chk("refresh advanced", 16'h1, {15'h0, refreshRow != row0});
      chk("loc ack under refresh", 16'h1, {15'h0, ok});
   endtask
   task automatic complete_run();
      if (n_fail == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever
         #20 clk = ~clk;
   end
   initial
   begin
      repeat (20000)
         @(posedge clk);
      n_fail++;
      complete_run();
   end
   initial
   begin
      rst_n = 1'b0;
      locReq = 1'b0;
      locWrite = 1'b0;
      locAddr = 20'h00000;
      locWdata = 16'h0000;
      sysBaseStrap = 7'h05;
      protEnStrap = 1'b1;
      protLoStrap = 2'h3;
      protHiStrap = 2'h3;
      repeat (16)
         @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk("refreshRow reset", 16'h0, {9'h0, refreshRow});
      t_local();
      t_sysport();
      t_protect();
      t_priority();
      t_straps();
      t_refresh();
      complete_run();
   end
endmodule

/* tb/dpc_sys_master.sv */
// system-bus master model: holds each request until acknowledged or 40 cycles pass
module dpc_sys_master
(
   input wire logic clk,
   input wire logic sysAck,
   input wire logic [dpc_pkg::DATA_W-1:0] sysRdata,
   output logic sysReq,
   output logic sysWrite,
   output logic sysByte,
   output logic [dpc_pkg::ADDR_W-1:0] sysAddr,
   output logic [dpc_pkg::DATA_W-1:0] sysWdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import dpc_pkg::*;
   initial
   begin
      sysReq = 1'b0;
      sysWrite = 1'b0;
      sysByte = 1'b0;
      sysAddr = 20'hfffff;
      sysWdata = 16'hffff;
   end
   // no ack within 40 cycles is taken as a miss, as a real master times out
   task automatic xfer(input logic wr, input logic byt, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic ok);
      int n;
      ok = 1'b0;
      rd = 16'h0000;
      @(posedge clk);
      #1;
      sysWrite = wr;
      sysByte = byt;
      sysAddr = a;
      sysWdata = wd;
      sysReq = 1'b1;
      for (n = 0; n < 40 && !ok; n++)
      begin
         @(posedge clk);
         #1;
         ok = (sysAck === 1'b1);
      end
      // keep the request up through the edge that samples the ack high
      @(posedge clk);
      #1;
      if (ok)
         rd = sysRdata;
      sysReq = 1'b0;
      // released address and data lines show no stale value
      sysAddr = ~a;
      sysWdata = ~wd;
      for (n = 0; n < 10 && sysAck !== 1'b0; n++)
         @(posedge clk);
   endtask
endmodule
